// >>> src/flash_read_pkg.sv
package flash_read_pkg;

    // ***************************************************************
    // Opcodes
    // ***************************************************************
    localparam logic [7:0] OPC_QUAD_OUT = 8'h6B;
    localparam logic [7:0] OPC_DUAL_IO  = 8'hBB;
    localparam logic [7:0] OPC_QUAD_IO  = 8'hEB;
    localparam logic [7:0] OPC_WORD_QIO = 8'hE7;

    // ***************************************************************
    // Serial clock counts per phase
    // ***************************************************************
    localparam logic [4:0] OPC_CLKS_SPI   = 5'h08;
    localparam logic [4:0] OPC_CLKS_QPI   = 5'h02;
    localparam logic [4:0] ADDR_CLKS_X1   = 5'h18;
    localparam logic [4:0] ADDR_CLKS_X2   = 5'h0C;
    localparam logic [4:0] ADDR_CLKS_X4   = 5'h06;
    localparam logic [4:0] MODE_CLKS_X2   = 5'h04;
    localparam logic [4:0] MODE_CLKS_X4   = 5'h02;
    localparam logic [4:0] DUMMY_QUAD_OUT = 5'h08;
    localparam logic [4:0] DUMMY_QIO_SPI  = 5'h04;
    localparam logic [4:0] DUMMY_WORD     = 5'h02;
    localparam logic [4:0] DUMMY_NONE     = 5'h00;

    // ***************************************************************
    // Mode bits, wrap and read parameters
    // ***************************************************************
    localparam logic [1:0] CONT_KEEP        = 2'b10;
    localparam int         WRAP_DISABLE_POS = 0;
    localparam logic [2:0] WRAP_CFG_RESET   = 3'h1;
    localparam logic [1:0] DUMMY_CFG_RESET  = 2'h0;
    localparam logic [8:0] WRAP_MIN_BYTES   = 9'h008;
    localparam logic [5:0] PIN_SYNC_RESET   = 6'h20;

    // ***************************************************************
    // Types
    // ***************************************************************
    typedef enum logic [2:0] {
        ST_IDLE, ST_OPCODE, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA, ST_IGNORE
    } phase_t;

    typedef enum logic [1:0] {
        CMD_QUAD_OUT, CMD_DUAL_IO, CMD_QUAD_IO, CMD_WORD_QIO
    } read_cmd_t;

    typedef struct packed {
        logic       csN;
        logic       sclk;
        logic [3:0] io;
    } pin_in_t;

    typedef struct packed {
        phase_t     phase;
        read_cmd_t  cmd;
        logic [4:0] cnt;
        logic [31:0] shiftIn;
        logic [23:0] addr;
        logic [7:0] shiftOut;
        logic [1:0] outIdx;
        logic [3:0] ioOut;
        logic [3:0] ioOe;
        logic       contMode;
        read_cmd_t  contCmd;
        logic [2:0] wrapCfg;
        logic [1:0] dummyCfg;
        logic       sclkPrev;
        logic       rejected;
    } engine_state_t;

    localparam engine_state_t ENGINE_RESET = '{
        phase:    ST_IDLE,
        cmd:      CMD_QUAD_OUT,
        contCmd:  CMD_QUAD_OUT,
        wrapCfg:  WRAP_CFG_RESET,
        dummyCfg: DUMMY_CFG_RESET,
        default:  '0
    };

endpackage

// >>> src/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
    parameter int               WIDTH     = 6,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    // Asynchronous inputs and their synchronised copies
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    // ***************************************************************
    // Two flip-flops per bit
    // ***************************************************************
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic firstStage;
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    firstStage <= RESET_VAL[i];
                    dout[i]    <= RESET_VAL[i];
                end else if (ce) begin
                    firstStage <= din[i];
                    dout[i]    <= firstStage;
                end
            end
        end
    endgenerate

endmodule

// >>> src/wrap_next_addr.sv
`timescale 1ns/1ps
module wrap_next_addr (
    // Current address and wrap setting
    input  wire logic [23:0] addr,
    input  wire logic        wrapOn,
    input  wire logic [1:0]  lenSel,
    // Address of the following byte
    output logic      [23:0] nextAddr
);
    import flash_read_pkg::*;

    logic [7:0]  mask;
    logic [23:0] inc;

    // ***************************************************************
    // Increment, folding back inside the aligned section
    // ***************************************************************
    always_comb begin
        mask     = 8'((WRAP_MIN_BYTES << lenSel) - 9'h001);
        inc      = addr + 24'h000001;
        nextAddr = inc;
        if (wrapOn) begin
            nextAddr = {addr[23:8], (addr[7:0] & ~mask) | (inc[7:0] & mask)};
        end
    end

endmodule

// >>> src/multi_io_fast_read_engine.sv
`timescale 1ns/1ps
// Function
// - Quad-output read opcode refused unless quad enable is set.
// - Quad-output read: opcode and address serial, data four bits per clock.
// - Quad-output read has eight dummy clocks after the 24-bit address.
// - Dual I/O read takes the 24 address bits two per clock.
// - Continuous-read byte follows address; its bits 5:4 steer next read.
// - Select pair 10 lets next dual I/O read start at the address.
// - Any other select pair leaves continuous mode; opcode needed next time.
// - Single-wire quad I/O read: four lines, exactly four dummy clocks.
// - Quad I/O opcode accepted only with quad enable set.
// - Quad I/O select pair 10 lets the next read skip the opcode.
// - With wrap on, quad I/O output wraps inside its aligned section.
// - Wrap setting: one disable bit and two section length bits.
// - Four-wire mode quad I/O dummy count 2/4/6/8, default 2.
// - Four-wire mode: mode byte clocks count toward the dummy clocks.
// - Opcode skipping also works in four-wire command mode.
// - Four-wire mode quad I/O read ignores the wrap setting.
// - Word quad I/O read: two dummy clocks, opcode needs quad enable.
// - Word quad I/O select pair 10 lets the next read skip the opcode.
// - Wrap disable bit low enables; length 8/16/32/64; disable resets high.
// - Address increments after each output byte while the clock runs.
module multi_io_fast_read_engine (
    // Clock, reset, enable
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // Serial pins
    input  wire logic        csN,
    input  wire logic        sclk,
    input  wire logic [3:0]  ioIn,
    output logic      [3:0]  ioOut,
    output logic      [3:0]  ioOe,
    // Configuration
    input  wire logic        quadEnable,
    input  wire logic        fourWireMode,
    input  wire logic        wrapLoad,
    input  wire logic [2:0]  wrapValue,
    input  wire logic        paramLoad,
    input  wire logic [1:0]  paramValue,
    // Memory array
    output logic      [23:0] memAddr,
    input  wire logic [7:0]  memData,
    // Status
    output logic             readActive,
    output logic             contModeActive,
    output logic             cmdRejected
);
    import flash_read_pkg::*;

    // ***************************************************************
    // Pin synchronisers and edges
    // ***************************************************************
    engine_state_t stateReg;
    engine_state_t stateNext;
    pin_in_t       pin;
    logic [5:0]    pinSync;
    logic          rise;
    logic          fall;
    logic [2:0]    inWidth;
    logic [31:0]   inShift;
    logic [23:0]   addrNext;
    logic          wrapActive;
    logic [4:0]    dummyNeed;
    logic [4:0]    addrClks;
    logic [4:0]    modeClks;
    logic [4:0]    opcClks;

    pin_sync #(
        .WIDTH     (6),
        .RESET_VAL (PIN_SYNC_RESET)
    ) u_pin_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .din   ({csN, sclk, ioIn}),
        .dout  (pinSync)
    );

    assign pin  = pin_in_t'(pinSync);
    assign rise = pin.sclk & ~stateReg.sclkPrev;
    assign fall = ~pin.sclk & stateReg.sclkPrev;

    // ***************************************************************
    // Lane widths and phase lengths
    // ***************************************************************
    always_comb begin
        inWidth = 3'd1;
        if (stateReg.phase == ST_OPCODE) begin
            inWidth = fourWireMode ? 3'd4 : 3'd1;
        end else if (stateReg.cmd == CMD_DUAL_IO) begin
            inWidth = 3'd2;
        end else if (stateReg.cmd != CMD_QUAD_OUT) begin
            inWidth = 3'd4;
        end
        case (inWidth)
            3'd2:    inShift = {stateReg.shiftIn[29:0], pin.io[1:0]};
            3'd4:    inShift = {stateReg.shiftIn[27:0], pin.io};
            default: inShift = {stateReg.shiftIn[30:0], pin.io[0]};
        endcase
        opcClks  = fourWireMode ? OPC_CLKS_QPI : OPC_CLKS_SPI;
        addrClks = ADDR_CLKS_X4;
        modeClks = MODE_CLKS_X4;
        case (stateReg.cmd)
            CMD_QUAD_OUT: begin
                addrClks  = ADDR_CLKS_X1;
                dummyNeed = DUMMY_QUAD_OUT;
            end
            CMD_DUAL_IO: begin
                addrClks  = ADDR_CLKS_X2;
                modeClks  = MODE_CLKS_X2;
                dummyNeed = DUMMY_NONE;
            end
            CMD_QUAD_IO: begin
                // Mode clocks are part of the four-wire dummy total
                dummyNeed = fourWireMode ? 5'({stateReg.dummyCfg, 1'b0})
                                         : DUMMY_QIO_SPI;
            end
            default: dummyNeed = DUMMY_WORD;
        endcase
    end

    // ***************************************************************
    // Output address stepping with wrap
    // ***************************************************************
    assign wrapActive = !fourWireMode
                      && !stateReg.wrapCfg[WRAP_DISABLE_POS]
                      && (stateReg.cmd == CMD_QUAD_IO
                       || stateReg.cmd == CMD_WORD_QIO);

    wrap_next_addr u_wrap_next_addr (
        .addr     (stateReg.addr),
        .wrapOn   (wrapActive),
        .lenSel   (stateReg.wrapCfg[2:1]),
        .nextAddr (addrNext)
    );

    // ***************************************************************
    // Command sequencer
    // ***************************************************************
    always_comb begin
        logic [7:0] opc;
        logic [7:0] outByte;
        opc      = inShift[7:0];
        outByte  = stateReg.shiftOut;
        stateNext          = stateReg;
        stateNext.rejected = 1'b0;
        stateNext.sclkPrev = pin.sclk;
        if (wrapLoad) begin
            stateNext.wrapCfg = wrapValue;
        end
        if (paramLoad) begin
            stateNext.dummyCfg = paramValue;
        end
        if (pin.csN) begin
            stateNext.phase  = ST_IDLE;
            stateNext.ioOe   = 4'h0;
            stateNext.ioOut  = 4'h0;
            stateNext.cnt    = 5'h00;
            stateNext.outIdx = 2'h0;
        end else begin
            case (stateReg.phase)
                ST_IDLE: begin
                    stateNext.cnt = 5'h00;
                    if (stateReg.contMode) begin
                        stateNext.phase = ST_ADDR;
                        stateNext.cmd   = stateReg.contCmd;
                    end else begin
                        stateNext.phase = ST_OPCODE;
                    end
                end
                ST_OPCODE: if (rise) begin
                    stateNext.shiftIn = inShift;
                    stateNext.cnt     = stateReg.cnt + 5'h01;
                    if (stateReg.cnt == opcClks - 5'h01) begin
                        stateNext.cnt   = 5'h00;
                        stateNext.phase = ST_ADDR;
                        if (opc == OPC_QUAD_OUT && !fourWireMode) begin
                            stateNext.cmd = CMD_QUAD_OUT;
                            if (!quadEnable) begin
                                stateNext.phase    = ST_IGNORE;
                                stateNext.rejected = 1'b1;
                            end
                        end else if (opc == OPC_DUAL_IO && !fourWireMode) begin
                            stateNext.cmd = CMD_DUAL_IO;
                        end else if (opc == OPC_QUAD_IO
                            || (opc == OPC_WORD_QIO && !fourWireMode)) begin
                            stateNext.cmd = (opc == OPC_QUAD_IO) ? CMD_QUAD_IO
                                          : CMD_WORD_QIO;
                            if (!quadEnable) begin
                                stateNext.phase    = ST_IGNORE;
                                stateNext.rejected = 1'b1;
                            end
                        end else begin
                            stateNext.phase = ST_IGNORE;
                        end
                    end
                end
                ST_ADDR: if (rise) begin
                    stateNext.shiftIn = inShift;
                    stateNext.cnt     = stateReg.cnt + 5'h01;
                    if (stateReg.cnt == addrClks - 5'h01) begin
                        stateNext.cnt  = 5'h00;
                        stateNext.addr = inShift[23:0];
                        stateNext.phase = (stateReg.cmd == CMD_QUAD_OUT)
                                        ? ST_DUMMY : ST_MODE;
                    end
                end
                ST_MODE: if (rise) begin
                    stateNext.shiftIn = inShift;
                    stateNext.cnt     = stateReg.cnt + 5'h01;
                    if (stateReg.cnt == modeClks - 5'h01) begin
                        stateNext.cnt = 5'h00;
                        stateNext.contMode =
                            (inShift[5:4] == CONT_KEEP);
                        stateNext.contCmd  = stateReg.cmd;
                        stateNext.outIdx   = 2'h0;
                        stateNext.phase    = (dummyNeed == DUMMY_NONE)
                                           ? ST_DATA : ST_DUMMY;
                    end
                end
                ST_DUMMY: if (rise) begin
                    // IO values during dummy clocks are not looked at
                    stateNext.cnt = stateReg.cnt + 5'h01;
                    if (stateReg.cnt == dummyNeed - 5'h01) begin
                        stateNext.cnt    = 5'h00;
                        stateNext.outIdx = 2'h0;
                        stateNext.phase  = ST_DATA;
                    end
                end
                ST_DATA: if (fall) begin
                    if (stateReg.outIdx == 2'h0) begin
                        outByte        = memData;
                        stateNext.addr = addrNext;
                    end
                    if (stateReg.cmd == CMD_DUAL_IO) begin
                        stateNext.ioOe     = 4'h3;
                        stateNext.ioOut    = {2'b00, outByte[7:6]};
                        stateNext.shiftOut = {outByte[5:0], 2'b00};
                        stateNext.outIdx   = stateReg.outIdx + 2'h1;
                    end else begin
                        stateNext.ioOe     = 4'hF;
                        stateNext.ioOut    = outByte[7:4];
                        stateNext.shiftOut = {outByte[3:0], 4'h0};
                        stateNext.outIdx   = {1'b0, ~stateReg.outIdx[0]};
                    end
                end
                ST_IGNORE: stateNext.ioOe = 4'h0;
                default:   stateNext.phase = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stateReg <= ENGINE_RESET;
        end else if (ce) begin
            stateReg <= stateNext;
        end
    end

    // ***************************************************************
    // Outputs
    // ***************************************************************
    assign ioOut          = stateReg.ioOut;
    assign ioOe           = stateReg.ioOe;
    assign memAddr        = stateReg.addr;
    assign readActive     = (stateReg.phase != ST_IDLE)
                         && (stateReg.phase != ST_IGNORE);
    assign contModeActive = stateReg.contMode;
    assign cmdRejected    = stateReg.rejected;

    // ***************************************************************
    // Checks
    // ***************************************************************
    logic [4:0] dummyRises;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dummyRises <= 5'h00;
        end else if (ce) begin
            if (stateReg.phase != ST_DUMMY || pin.csN) begin
                dummyRises <= 5'h00;
            end else if (rise) begin
                dummyRises <= dummyRises + 5'h01;
            end
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence csHigh;
        ce && pin.csN;
    endsequence

    sequence csLowInContinuous;
        ce && !pin.csN && stateReg.phase == ST_IDLE && stateReg.contMode;
    endsequence

    sequence lastDummyRise(read_cmd_t c);
        ce && rise && !pin.csN && stateReg.phase == ST_DUMMY
        && stateReg.cmd == c && stateReg.cnt == dummyNeed - 5'h01;
    endsequence

    a_cs_ends_read: assert property (
        csHigh |=> (stateReg.ioOe == 4'h0 && stateReg.phase == ST_IDLE))
        else $error("IO still driven or decoder busy after chip select high");

    a_cont_skip_opcode: assert property (
        csLowInContinuous |=> (stateReg.phase == ST_ADDR
                               && stateReg.cmd == $past(stateReg.contCmd)))
        else $error("continuous mode did not skip the opcode");

    a_quad_out_dummy: assert property (
        lastDummyRise(CMD_QUAD_OUT) |-> (dummyRises == 5'd7)
                                        ##1 (stateReg.phase == ST_DATA))
        else $error("quad output read dummy count is not eight");

    a_qio_spi_dummy: assert property (
        (lastDummyRise(CMD_QUAD_IO) and !fourWireMode)
            |-> (dummyRises == 5'd3) ##1 (stateReg.phase == ST_DATA))
        else $error("quad I/O read dummy count is not four");

    a_word_dummy: assert property (
        lastDummyRise(CMD_WORD_QIO) |-> (dummyRises == 5'd1)
                                        ##1 (stateReg.phase == ST_DATA))
        else $error("word quad I/O read dummy count is not two");

    a_quad_out_reject: assert property (
        (ce && rise && !pin.csN && stateReg.phase == ST_OPCODE
         && !fourWireMode && stateReg.cnt == 5'd7
         && inShift[7:0] == OPC_QUAD_OUT && !quadEnable)
        |=> (stateReg.phase == ST_IGNORE && cmdRejected)
            ##1 !cmdRejected)
        else $error("quad output read accepted without quad enable");

    a_lane_width: assert property (
        (stateReg.ioOe != 4'h0) |->
            stateReg.ioOe == ((stateReg.cmd == CMD_DUAL_IO) ? 4'h3 : 4'hF))
        else $error("wrong IO lines driven for this read");

    a_cont_exit: assert property (
        (ce && rise && !pin.csN && stateReg.phase == ST_MODE
         && stateReg.cnt == modeClks - 5'h01 && inShift[5:4] != CONT_KEEP)
        |=> !contModeActive)
        else $error("continuous mode kept with select pair not 10");

    a_addr_advance: assert property (
        (ce && fall && !pin.csN && stateReg.phase == ST_DATA
         && stateReg.outIdx == 2'h0 && !wrapActive)
        |=> memAddr == $past(memAddr) + 24'h000001)
        else $error("address did not step after a byte");

    a_wrap_section: assert property (
        (ce && fall && !pin.csN && stateReg.phase == ST_DATA && wrapActive
         && stateReg.outIdx == 2'h0 && stateReg.wrapCfg[2:1] == 2'b00)
        |=> (memAddr[23:3] == $past(memAddr[23:3])))
        else $error("wrapped read left its section");

endmodule

// >>> verification/flash_host_model.sv
`timescale 1ns/1ps
module flash_host_model (
    // Clock and pins
    input  wire logic       clk,
    output logic            csN,
    output logic            sclk,
    output logic      [3:0] io,
    input  wire logic [3:0] ioOut
);
    logic rel = 1'b0;
    initial begin
        csN = 1'b1;
        sclk = 1'b0;
        io = 4'h0;
    end
    // Released lines toggle, never hold stale data
    always @(posedge clk) begin
        if (rel) begin
            io <= ~io;
        end
    end
    task automatic pulse(input logic [3:0] v, output logic [3:0] s);
        if (!rel) begin
            io <= v;
        end
        repeat (5) @(posedge clk);
        #1 s = ioOut;
        @(posedge clk) sclk <= 1'b1;
        repeat (6) @(posedge clk);
        sclk <= 1'b0;
    endtask
    task automatic cs(input logic v);
        repeat (6) @(posedge clk);
        csN <= v;
        rel = 1'b0;
        repeat (12) @(posedge clk);
    endtask
    task automatic send(input logic [31:0] v, input int n, input int w);
        logic [3:0] s;
        for (int i = n - w; i >= 0; i -= w) begin
            pulse(4'((v >> i) & ((1 << w) - 1)), s);
        end
    endtask
    // Dummy clocks with lines released
    task automatic dummy(input int n);
        logic [3:0] s;
        rel = 1'b1;
        repeat (n) pulse(4'h0, s);
    endtask
    task automatic get(input int w, output logic [7:0] b);
        logic [3:0] s;
        rel = 1'b1;
        b = 8'h00;
        repeat (8 / w) begin
            pulse(4'h0, s);
            b = 8'((b << w) | (s & 4'((1 << w) - 1)));
        end
    endtask
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import flash_read_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        csN, sclk, ra, cm, rj, rejSeen;
    logic        ce, qe, fw, wl, pl;
    logic [2:0]  wv;
    logic [1:0]  pv;
    logic [3:0]  ioIn, ioOut, ioOe;
    logic [23:0] memAddr;
    logic [7:0]  memData;
    int          fail_count = 0;
    int          samples_checked = 0;
    always #2 clk = ~clk;
    function automatic logic [7:0] memOf(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5A;
    endfunction
    assign memData = memOf(memAddr);
    always @(posedge clk) if (rj === 1'b1) rejSeen <= 1'b1;
    multi_io_fast_read_engine i_dut (
        .clk(clk), .rst_n(rst_n), .ce(ce), .csN(csN), .sclk(sclk),
        .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe), .quadEnable(qe),
        .fourWireMode(fw), .wrapLoad(wl), .wrapValue(wv),
        .paramLoad(pl), .paramValue(pv), .memAddr(memAddr),
        .memData(memData), .readActive(ra), .contModeActive(cm),
        .cmdRejected(rj));
    flash_host_model i_host (
        .clk(clk), .csN(csN), .sclk(sclk), .io(ioIn), .ioOut(ioOut));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [7:0] op, input int ow, input int aw,
                      input logic [23:0] a, input logic [7:0] m,
                      input int dm, input int dw, input logic [23:0] k,
                      input int n);
        logic [7:0] b;
        i_host.cs(1'b0);
        if (ow > 0) i_host.send(op, 8, ow);
        i_host.send(a, 24, aw);
        if (aw > 1) i_host.send(m, 8, aw);
        i_host.dummy(dm);
        for (int i = 0; i < n; i++) begin
            i_host.get(dw, b);
            check(b, memOf((a & ~k) | ((a + i) & k)));
        end
        check(ioOe, (dw == 2) ? 4'h3 : 4'hF);
        i_host.cs(1'b1);
        check({ioOe, ra}, 5'h00);
    endtask
    task automatic t_reject(input logic [7:0] op);
        logic [7:0] b;
        rejSeen <= 1'b0;
        i_host.cs(1'b0);
        i_host.send({op, 24'h000010}, 32, 1);
        i_host.dummy(8);
        i_host.get(4, b);
        check({rejSeen, ioOe}, 5'h10);
        i_host.cs(1'b1);
    endtask
    task automatic t_quad();
        qe <= 1'b1;
        rd(OPC_QUAD_OUT, 1, 1, 24'h0123FE, 8'h00, 8, 4, 24'hFFFFFF, 3);
        rd(OPC_QUAD_IO, 1, 4, 24'h000407, 8'h00, 4, 4, 24'hFFFFFF, 2);
    endtask
    task automatic t_dual();
        rd(OPC_DUAL_IO, 1, 2, 24'h00A0FF, 8'h2F, 0, 2, 24'hFFFFFF, 2);
        check(cm, 1'b1);
        rd(OPC_DUAL_IO, 0, 2, 24'h0012C4, 8'hF0, 0, 2, 24'hFFFFFF, 2);
        check(cm, 1'b0);
        rd(OPC_DUAL_IO, 1, 2, 24'h000301, 8'h00, 0, 2, 24'hFFFFFF, 1);
        rd(OPC_DUAL_IO, 1, 2, 24'h000310, 8'h20, 0, 2, 24'hFFFFFF, 1);
        t_exit(16);
    endtask
    task automatic t_wrap();
        for (int w = 0; w < 4; w++) begin
            wv <= {w[1:0], 1'b0};
            wl <= 1'b1;
            @(posedge clk) wl <= 1'b0;
            rd(OPC_QUAD_IO, 1, 4, 24'h000500 + (8 << w) - 2, 8'h00, 4, 4,
               24'((8 << w) - 1), 3);
        end
    endtask
    task automatic t_four();
        fw <= 1'b1;
        for (int p = 0; p < 4; p++) begin
            if (p > 0) begin
                pv <= 2'(p);
                pl <= 1'b1;
                @(posedge clk) pl <= 1'b0;
            end
            rd(OPC_QUAD_IO, 4, 4, 24'h00003F, 8'h00, 2 * p, 4, 24'hFFFFFF,
               2);
        end
        rd(OPC_QUAD_IO, 4, 4, 24'h000123, 8'h20, 6, 4, 24'hFFFFFF, 1);
        rd(OPC_QUAD_IO, 0, 4, 24'h000456, 8'hFF, 6, 4, 24'hFFFFFF, 1);
        check(cm, 1'b0);
        fw <= 1'b0;
    endtask
    task automatic t_word();
        rd(OPC_WORD_QIO, 1, 4, 24'h000104, 8'h20, 2, 4, 24'hFFFFFF, 2);
        check(cm, 1'b1);
        rd(OPC_WORD_QIO, 0, 4, 24'h000208, 8'hFF, 2, 4, 24'hFFFFFF, 2);
        rd(OPC_QUAD_IO, 1, 4, 24'h000400, 8'h20, 4, 4, 24'hFFFFFF, 1);
        rd(OPC_QUAD_IO, 0, 4, 24'h000600, 8'h00, 4, 4, 24'hFFFFFF, 1);
        rd(OPC_QUAD_IO, 1, 4, 24'h000700, 8'h20, 4, 4, 24'hFFFFFF, 1);
        t_exit(8);
    endtask
    task automatic t_exit(input int n);
        i_host.cs(1'b0);
        i_host.send(32'h0000FFFF, n, 1);
        i_host.cs(1'b1);
        check(cm, 1'b0);
    endtask
    task automatic t_freeze();
        ce <= 1'b0;
        i_host.cs(1'b0);
        check(ra, 1'b0);
        ce <= 1'b1;
        repeat (4) @(posedge clk);
        check(ra, 1'b1);
        i_host.cs(1'b1);
    endtask
    task automatic complete_run();
        $display("fail_count=%0d samples_checked=%0d", fail_count,
                 samples_checked);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ***************************************************************
    // Sequence and watchdog
    // ***************************************************************
    initial begin
        ce <= 1'b1;
        qe <= 1'b0;
        fw <= 1'b0;
        wl <= 1'b0;
        pl <= 1'b0;
        wv <= 3'h1;
        pv <= 2'h0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_freeze();
        t_reject(OPC_QUAD_OUT);
        t_reject(OPC_QUAD_IO);
        t_reject(OPC_WORD_QIO);
        t_quad();
        t_dual();
        t_wrap();
        t_four();
        t_word();
        complete_run();
    end
    initial begin
        #200000;
        fail_count++;
        complete_run();
    end
endmodule
